// *** common/tprs_defines.svh ***
// constants of the tape power restart sequencer
`ifndef TPRS_DEFINES_SVH
`define TPRS_DEFINES_SVH

// ********************************************************
// timing
// ********************************************************
`define TPRS_CLK_HZ            50000000
`define TPRS_SEQ_PERIOD_MS     500
`define TPRS_SEARCH_TIMEOUT_MS 6000
`define TPRS_SEARCH_TICKS      (`TPRS_SEARCH_TIMEOUT_MS / `TPRS_SEQ_PERIOD_MS)
`define TPRS_DIV_W             25
`define TPRS_TMR_W             4

// ********************************************************
// register map
// ********************************************************
`define TPRS_ADDR_W        8
`define TPRS_ADDR_CTRL     8'h00
`define TPRS_ADDR_STATUS   8'h04
`define TPRS_CTRL_RESET    4'h0
`define TPRS_RESP_OKAY     2'h0
`define TPRS_RESP_SLVERR   2'h2

`endif

// *** common/tprs_pkg.sv ***
// types of the tape power restart sequencer
package tprs_pkg;

  typedef enum logic [15:0] {
    st_0 = 16'h0001,
    st_1 = 16'h0002,
    st_2 = 16'h0004,
    st_3 = 16'h0008,
    st_4 = 16'h0010,
    st_5 = 16'h0020,
    st_6 = 16'h0040,
    st_7 = 16'h0080,
    st_8 = 16'h0100,
    st_9 = 16'h0200,
    st_a = 16'h0400,
    st_b = 16'h0800,
    st_c = 16'h1000,
    st_d = 16'h2000,
    st_e = 16'h4000,
    st_f = 16'h8000
  } tprs_state_e;

  // option straps, software controlled
  typedef struct packed {
    logic remote_load_online;
    logic power_restart;
    logic fast_motion_option;
    logic online_lock;
  } tprs_ctrl_s;

  // interface and deck pins, all asynchronous to aclk
  typedef struct packed {
    logic select;
    logic fast_fwd;
    logic fast_rev;
    logic offline_permit;
    logic remote_load_online_n;
    logic master_clear;
    logic power_good;
    logic broken_sensor;
    logic tape_start_marker;
    logic past_tape_start;
    logic past_tape_end;
    logic panel_online;
    logic panel_offline;
  } tprs_link_in_s;

  typedef struct packed {
    logic broken_tape;
    logic servo_disable;
    logic write_inhibit;
    logic online;
    logic loaded;
    logic run_normal;
    logic rewind;
    logic run_fast_fwd;
    logic run_fast_rev;
    logic run_sync_fwd;
    logic restart_enable;
  } tprs_link_out_s;

endpackage : tprs_pkg

// *** logic/tprs_tick_div.sv ***
// sequencing clock divider: one-cycle tick every CYCLES clocks
`timescale 1ns/1ns
`include "tprs_defines.svh"
module tprs_tick_div
#(
  parameter int unsigned CYCLES = 1
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);

  localparam logic [`TPRS_DIV_W-1:0] LAST = `TPRS_DIV_W'(CYCLES - 1);

  logic [`TPRS_DIV_W-1:0] cnt_ff;
  logic                   tick_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff  <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (cnt_ff == LAST);
      cnt_ff  <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    end
  end

  assign tick = tick_ff;

endmodule : tprs_tick_div

// *** logic/tprs_top.sv ***
// tape power restart sequencer with lock, fast motion and register slave
// Contract
// - lock ignores panel offline without controller permit
// - lock not qualified by select
// - fast commands only when online and selected
// - fast reverse only beyond start marker
// - fast forward only between the markers
// - past end marker, fast forward runs synchronous
// - power loss: offline, broken tape, servos off
// - recovery: reload and online only if armed
// - restart armed online, disarmed going offline
// - remote load only after unloaded power dip
// - remote load not qualified by select
// - load searches start marker, rewinds on timeout
// - states 0,1 broken tape; 2,3 silent
// - state 4 jumps F on remote load
// - 8-9 load, A-B on tape, C-D online
// - sequencing tick period 0.5 second
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ns
`include "tprs_defines.svh"
module tprs_top
  import tprs_pkg::*;
#(
  parameter int unsigned SEQ_PERIOD_CYCLES = `TPRS_CLK_HZ / 1000 * `TPRS_SEQ_PERIOD_MS
)
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [`TPRS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [`TPRS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire tprs_link_in_s           link_in,
  output tprs_link_out_s               link_out
);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ********************************************************
  // pin synchronisers and edges
  // ********************************************************
  tprs_link_in_s link_meta_ff;
  tprs_link_in_s link_sync_ff;
  tprs_link_in_s link_prev_ff;
  logic          pf_prev_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      link_meta_ff <= '0;
      link_sync_ff <= '0;
      link_prev_ff <= '0;
      pf_prev_ff   <= 1'b1;
    end
    else
    begin
      link_meta_ff <= link_in;
      link_sync_ff <= link_meta_ff;
      link_prev_ff <= link_sync_ff;
      pf_prev_ff   <= !link_sync_ff.power_good;
    end
  end

  tprs_ctrl_s  ctrl_ff;
  logic        tick;
  logic        power_fail;
  logic        fail_edge;
  logic        on_req;
  logic        off_req;
  logic        lock_hold;
  logic        mclr;
  logic        lol_req;

  assign power_fail = !link_sync_ff.power_good;
  assign fail_edge  = power_fail && !pf_prev_ff;
  assign on_req     = link_sync_ff.panel_online && !link_prev_ff.panel_online;
  assign off_req    = link_sync_ff.panel_offline && !link_prev_ff.panel_offline;
  // select deliberately absent from both terms below
  assign lock_hold  = ctrl_ff.online_lock && !link_sync_ff.offline_permit;
  assign mclr       = link_sync_ff.master_clear || power_fail;

  tprs_tick_div #(
    .CYCLES (SEQ_PERIOD_CYCLES)
  ) u_tick_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // ********************************************************
  // restart sequencer
  // ********************************************************
  function automatic logic in_pair(tprs_state_e s, tprs_state_e a, tprs_state_e b);
    in_pair = (s == a) || (s == b);
  endfunction : in_pair

  tprs_state_e state_ff;
  tprs_state_e nxt_state;
  logic        armed_ff;
  logic        lol_ok_ff;
  logic        broken_w;
  logic        brk;

  assign brk     = power_fail || link_sync_ff.broken_sensor;
  // a 500 ms low pulse always spans one tick
  assign lol_req = lol_ok_ff && !link_sync_ff.remote_load_online_n;

  always_comb
  begin
    nxt_state = state_ff;
    if (tick)
    begin
      case (state_ff)
        st_0:    nxt_state = mclr ? st_0 : st_1;
        st_1:    nxt_state = mclr ? st_0 : st_2;
        st_2:    nxt_state = mclr ? st_0 : st_3;
        st_3:    nxt_state = mclr ? st_0 : st_4;
        // with neither cause it waits here: recovery does nothing
        st_4:    nxt_state = mclr ? st_0 : lol_req ? st_f : armed_ff ? st_5 : st_4;
        st_5:    nxt_state = mclr ? st_0 : st_6;
        st_6:    nxt_state = mclr ? st_0 : st_7;
        st_7:    nxt_state = mclr ? st_0 : st_8;
        st_8:    nxt_state = mclr ? st_0 : st_9;
        st_9:    nxt_state = mclr ? st_0 : st_a;
        st_a:    nxt_state = mclr ? st_0 : st_b;
        st_b:    nxt_state = mclr ? st_0 : st_c;
        st_c:    nxt_state = mclr ? st_0 : st_d;
        st_d:    nxt_state = mclr ? st_0 : st_e;
        st_e:    nxt_state = mclr ? st_0 : st_e;
        st_f:    nxt_state = brk ? st_0 : st_f;
        default: nxt_state = st_0;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_ff <= st_0;
    else
      state_ff <= nxt_state;
  end

  logic load_set_w;
  logic on_tape_set_w;
  logic online_set_w;
  logic enable_w;

  assign broken_w      = power_fail || in_pair(state_ff, st_0, st_1);
  assign load_set_w    = in_pair(state_ff, st_8, st_9);
  assign on_tape_set_w = in_pair(state_ff, st_a, st_b);
  assign online_set_w  = in_pair(state_ff, st_c, st_d);
  assign enable_w      = in_pair(state_ff, st_e, st_f);

  // ********************************************************
  // load, search for start marker, timeout rewind
  // ********************************************************
  logic                   loaded_ff;
  logic                   on_tape_ff;
  logic                   search_ff;
  logic                   rewind_ff;
  logic [`TPRS_TMR_W-1:0] tmr_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || broken_w)
    begin
      loaded_ff  <= 1'b0;
      on_tape_ff <= 1'b0;
      search_ff  <= 1'b0;
      rewind_ff  <= 1'b0;
      tmr_ff     <= '0;
    end
    else
    begin
      if (load_set_w)
        loaded_ff <= 1'b1;
      if (on_tape_set_w && loaded_ff && !on_tape_ff && !search_ff && !rewind_ff)
      begin
        search_ff <= 1'b1;
        tmr_ff    <= '0;
      end
      if (search_ff)
      begin
        if (link_sync_ff.tape_start_marker)
        begin
          search_ff  <= 1'b0;
          on_tape_ff <= 1'b1;
        end
        else if (tick && tmr_ff == `TPRS_TMR_W'(`TPRS_SEARCH_TICKS - 1))
        begin
          search_ff <= 1'b0;
          rewind_ff <= 1'b1;
        end
        else if (tick)
          tmr_ff <= tmr_ff + 1'b1;
      end
      if (rewind_ff && link_sync_ff.tape_start_marker)
      begin
        rewind_ff  <= 1'b0;
        on_tape_ff <= 1'b1;
      end
    end
  end

  // ********************************************************
  // on line, arming, remote load qualification
  // ********************************************************
  logic online_ff;
  logic online_pend_ff;
  logic go_online;
  logic panel_drop;

  assign panel_drop = online_ff && off_req && !lock_hold;
  // no on-tape option here: the panel may put a deck on line unloaded
  assign go_online  = !online_ff && !broken_w
                      && (on_req || (online_pend_ff && on_tape_ff));

  always_ff @(posedge aclk)
  begin
    if (!aresetn || power_fail)
      online_ff <= 1'b0;
    else if (panel_drop)
      online_ff <= 1'b0;
    else if (go_online)
      online_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || broken_w || go_online)
      online_pend_ff <= 1'b0;
    else if (online_set_w)
      online_pend_ff <= 1'b1;
  end

  // a forced drop on power loss keeps it armed
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_ff.power_restart || panel_drop)
      armed_ff <= 1'b0;
    else if (go_online)
      armed_ff <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !ctrl_ff.remote_load_online)
      lol_ok_ff <= 1'b0;
    else if (fail_edge && !loaded_ff)
      lol_ok_ff <= 1'b1;
    else if (state_ff == st_f)
      lol_ok_ff <= 1'b0;
  end

  // ********************************************************
  // deck outputs
  // ********************************************************
  logic           fast_ok;
  tprs_link_out_s nxt_out;
  tprs_link_out_s out_ff;

  assign fast_ok = ctrl_ff.fast_motion_option && online_ff && link_sync_ff.select;

  always_comb
  begin
    nxt_out                = '0;
    nxt_out.broken_tape    = broken_w;
    nxt_out.servo_disable  = broken_w;
    nxt_out.write_inhibit  = broken_w;
    nxt_out.online         = online_ff;
    nxt_out.loaded         = loaded_ff;
    nxt_out.run_normal     = search_ff;
    nxt_out.rewind         = rewind_ff;
    nxt_out.restart_enable = enable_w;
    nxt_out.run_fast_rev   = fast_ok && link_sync_ff.fast_rev
                             && link_sync_ff.past_tape_start;
    nxt_out.run_fast_fwd   = fast_ok && link_sync_ff.fast_fwd && !link_sync_ff.past_tape_end
                             && (link_sync_ff.tape_start_marker
                                 || link_sync_ff.past_tape_start);
    nxt_out.run_sync_fwd   = fast_ok && link_sync_ff.fast_fwd
                             && link_sync_ff.past_tape_end;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      out_ff <= '0;
    else
      out_ff <= nxt_out;
  end

  assign link_out = out_ff;

  // ********************************************************
  // register slave
  // ********************************************************
  logic                    aw_got_ff;
  logic                    w_got_ff;
  logic [`TPRS_ADDR_W-1:0] awaddr_ff;
  logic [31:0]             wdata_ff;
  logic                    wlane0_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    rvalid_ff;
  logic [1:0]              rresp_ff;
  logic [31:0]             rdata_ff;
  logic                    wr_fire;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign wr_fire       = aw_got_ff && w_got_ff && !bvalid_ff;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff  <= '0;
      wlane0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `TPRS_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_ff  <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wlane0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff == `TPRS_ADDR_CTRL || awaddr_ff == `TPRS_ADDR_STATUS)
                     ? `TPRS_RESP_OKAY : `TPRS_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // all option bits live in byte lane 0
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_ff <= `TPRS_CTRL_RESET;
    else if (wr_fire && wlane0_ff && awaddr_ff == `TPRS_ADDR_CTRL)
      ctrl_ff <= wdata_ff[$bits(tprs_ctrl_s)-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= `TPRS_RESP_OKAY;
      rdata_ff  <= '0;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= `TPRS_RESP_OKAY;
      if (s_axi_araddr == `TPRS_ADDR_CTRL)
        rdata_ff <= 32'(ctrl_ff);
      else if (s_axi_araddr == `TPRS_ADDR_STATUS)
        rdata_ff <= 32'({lol_ok_ff, rewind_ff, search_ff, broken_w, on_tape_ff,
                         loaded_ff, armed_ff, online_ff, state_ff});
      else
      begin
        rdata_ff <= '0;
        rresp_ff <= `TPRS_RESP_SLVERR;
      end
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // ********************************************************
  // checks
  // ********************************************************
  a_lock_holds_online: assert property (
    online_ff && lock_hold && off_req && !power_fail |=> online_ff)
    else $error("locked deck went off line");
  a_fast_needs_select: assert property (
    !link_sync_ff.select |=> !out_ff.run_fast_fwd && !out_ff.run_fast_rev)
    else $error("fast motion while not selected");
  a_rev_past_start: assert property (
    out_ff.run_fast_rev |-> $past(link_sync_ff.past_tape_start))
    else $error("fast reverse not beyond start marker");
  a_fwd_past_end: assert property (
    fast_ok && link_sync_ff.fast_fwd && link_sync_ff.past_tape_end
    |=> out_ff.run_sync_fwd && !out_ff.run_fast_fwd)
    else $error("past end marker not synchronous forward");
  a_power_fail_off: assert property (
    power_fail |=> !online_ff && out_ff.broken_tape && out_ff.servo_disable
    && out_ff.write_inhibit)
    else $error("power loss did not force off line");
  a_state_one_tick: assert property (
    state_ff != $past(state_ff) |-> $past(tick))
    else $error("sequencer moved without tick");
  a_lol_jump_f: assert property (
    state_ff == st_4 && tick && lol_req && !mclr |=> state_ff == st_f)
    else $error("remote load did not jump to F");
  a_load_pair: assert property (
    tick && state_ff == st_7 && !mclr |=> load_set_w [*1] ##0 state_ff == st_8)
    else $error("load set not asserted after state 7");
  a_broken_states: assert property (
    state_ff == st_1 |=> out_ff.broken_tape)
    else $error("broken tape missing in state 1");
  a_disarm_offline: assert property (
    panel_drop |=> !armed_ff && !online_ff)
    else $error("restart still armed after off line");

endmodule : tprs_top

// *** test/tprs_ctl_model.sv ***
// tape controller model driving the interface side of the deck
`timescale 1ns/1ns
module tprs_ctl_model
#(
  parameter int unsigned PULSE_CYC = 40
)
(
  input  wire logic aclk,
  input  wire logic want_sel,
  input  wire logic want_ff,
  input  wire logic want_fr,
  input  wire logic want_permit,
  input  wire logic want_remote,
  output logic      select = 1'b0,
  output logic      fast_fwd = 1'b0,
  output logic      fast_rev = 1'b0,
  output logic      offline_permit = 1'b0,
  output logic      remote_load_online_n
);
  // ********************************************************
  // interface lines
  // ********************************************************
  logic [7:0] cnt_ff = 8'h00;

  // fast motion only while the bench asks for it, one clock later
  always_ff @(posedge aclk)
  begin
    select         <= want_sel;
    fast_fwd       <= want_ff;
    fast_rev       <= want_fr;
    offline_permit <= want_permit;
  end

  // once started the low pulse runs its full length
  always_ff @(posedge aclk)
  begin
    if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
    else if (want_remote)
      cnt_ff <= PULSE_CYC[7:0];
  end

  assign remote_load_online_n = (cnt_ff == 8'h00);
endmodule : tprs_ctl_model

// *** test/tb_tprs_top.sv ***
// self-checking testbench of the tape power restart sequencer
`timescale 1ns/1ns
`include "tprs_defines.svh"
module tb_tprs_top
  import tprs_pkg::*;
;
  localparam int unsigned SEQ = 20;
  logic           aclk = 1'b0;
  logic           aresetn = 1'b0;
  logic [7:0]     awaddr = 8'h00;
  logic [7:0]     araddr = 8'h00;
  logic [31:0]    wdata = 32'h0;
  logic [3:0]     wstrb = 4'h0;
  logic           awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic           arvalid = 1'b0, rready = 1'b0;
  logic           awready, wready, bvalid, arready, rvalid;
  logic [1:0]     bresp, rresp, rs;
  logic [31:0]    rdata, rd;
  logic           mc = 1'b0, pg = 1'b1, bs = 1'b0, mark = 1'b1;
  logic           ps = 1'b0, pe = 1'b0, pon = 1'b0, poff = 1'b0;
  logic           w_sel = 1'b1, w_ff = 1'b0, w_fr = 1'b0, w_perm = 1'b0, w_rl = 1'b0;
  logic           sel, ff, fr, perm, rl_n;
  tprs_link_in_s  link_in;
  tprs_link_out_s link_out;
  logic [10:0]    lo;
  logic [8:0]     rows [7];
  int             error_cnt = 0;
  int             checks = 0;

  assign link_in = {sel, ff, fr, perm, rl_n, mc, pg, bs, mark, ps, pe, pon, poff};
  assign lo = link_out;
  always #10 aclk = ~aclk;

  tprs_top #(.SEQ_PERIOD_CYCLES(SEQ)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link_in(link_in), .link_out(link_out));

  tprs_ctl_model #(.PULSE_CYC(2 * SEQ)) ctl (.aclk(aclk), .want_sel(w_sel), .want_ff(w_ff),
    .want_fr(w_fr), .want_permit(w_perm), .want_remote(w_rl), .select(sel), .fast_fwd(ff),
    .fast_rev(fr), .offline_permit(perm), .remote_load_online_n(rl_n));

  // ********************************************************
  // tasks
  // ********************************************************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic hang(input string nm);
    error_cnt++;
    $display("BAD %s exp done seen timeout", nm);
    wrap_up();
  endtask : hang

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1)
        awvalid <= 1'b0;
      if (wvalid && wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1 && n < 50);
    if (n >= 50)
      hang("write");
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (arvalid && arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1 && n < 50);
    if (n >= 50)
      hang("read");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // bound counts status reads, a few cycles each
  task automatic wait_st(input logic [31:0] v, input int lim);
    int n;
    n = 0;
    axr(`TPRS_ADDR_STATUS, rd, rs);
    while ((rd & 32'h0000ffff) !== v && n < lim)
    begin
      axr(`TPRS_ADDR_STATUS, rd, rs);
      n++;
    end
    if (n >= lim)
      hang("sequencer state");
  endtask : wait_st

  task automatic wait_lo(input int i, input logic v, input int lim);
    int n;
    n = 0;
    while (lo[i] !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim)
      hang("link_out bit");
  endtask : wait_lo

  task automatic push(input logic off);
    @(posedge aclk);
    poff <= off;
    pon <= !off;
    repeat (2) @(posedge aclk);
    poff <= 1'b0;
    pon <= 1'b0;
  endtask : push

  task automatic remote();
    @(posedge aclk);
    w_rl <= 1'b1;
    @(posedge aclk);
    w_rl <= 1'b0;
  endtask : remote

  // ********************************************************
  // main sequence
  // ********************************************************
  initial
  begin
    rows = '{9'h1a4, 9'h160, 9'h152, 9'h194, 9'h199, 9'h090, 9'h120};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    axr(`TPRS_ADDR_CTRL, rd, rs);
    chk("ctrl reset", 32'h0, rd);
    axr(`TPRS_ADDR_STATUS, rd, rs);
    chk("state after reset", 32'h0001, rd & 32'h0000ffff);
    chk("broken in state 0", 32'h1, {31'h0, lo[10]});
    axw(8'h10, 32'h5, rs);
    chk("unmapped bresp", `TPRS_RESP_SLVERR, rs);
    axr(8'h10, rd, rs);
    chk("unmapped rdata", 32'h0, rd);
    chk("unmapped rresp", `TPRS_RESP_SLVERR, rs);
    axw(`TPRS_ADDR_STATUS, 32'h0, rs);
    chk("status write bresp", `TPRS_RESP_OKAY, rs);
    axw(`TPRS_ADDR_CTRL, 32'h6, rs);
    axr(`TPRS_ADDR_CTRL, rd, rs);
    chk("ctrl readback", 32'h6, rd);
    wait_st(32'h0010, 100);
    chk("broken past state 1", 32'h0, {31'h0, lo[10]});
    $display("test registers and start done");
    for (int k = 0; k < 40 && lo[7] !== 1'b1; k++)
    begin
      push(1'b0);
      repeat (8) @(posedge aclk);
    end
    chk("online", 32'h1, {31'h0, lo[7]});
    axr(`TPRS_ADDR_STATUS, rd, rs);
    chk("armed", 32'h1, {31'h0, rd[17]});
    foreach (rows[i])
    begin
      {w_sel, w_ff, w_fr, mark, ps, pe} <= rows[i][8:3];
      repeat (6) @(posedge aclk);
      chk("fast outputs", {29'h0, rows[i][2:0]}, {29'h0, lo[3:1]});
    end
    $display("test fast motion done");
    pg <= 1'b0;
    mark <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("power loss outputs", 32'he, {28'h0, lo[10:7]});
    wait_st(32'h0001, 50);
    pg <= 1'b1;
    wait_lo(5, 1'b1, 600);
    wait_lo(4, 1'b1, 600);
    mark <= 1'b1;
    wait_lo(7, 1'b1, 300);
    chk("restart loaded", 32'h1, {31'h0, lo[6]});
    ps <= 1'b1;
    w_fr <= 1'b1;
    wait_lo(2, 1'b1, 20);
    w_fr <= 1'b0;
    ps <= 1'b0;
    $display("test restart done");
    axw(`TPRS_ADDR_CTRL, 32'hf, rs);
    w_sel <= 1'b0;
    push(1'b1);
    repeat (6) @(posedge aclk);
    chk("locked online", 32'h1, {31'h0, lo[7]});
    w_perm <= 1'b1;
    push(1'b1);
    wait_lo(7, 1'b0, 20);
    axr(`TPRS_ADDR_STATUS, rd, rs);
    chk("disarmed", 32'h0, {31'h0, rd[17]});
    $display("test online lock done");
    pg <= 1'b0;
    wait_st(32'h0001, 50);
    pg <= 1'b1;
    wait_st(32'h0010, 100);
    remote();
    repeat (3 * SEQ) @(posedge aclk);
    chk("idle online", 32'h0, {31'h0, lo[7]});
    chk("idle loaded", 32'h0, {31'h0, lo[6]});
    chk("remote ignored", 32'h0, {31'h0, lo[0]});
    mc <= 1'b1;
    wait_st(32'h0001, 50);
    chk("clear broken", 32'h1, {31'h0, lo[10]});
    mc <= 1'b0;
    $display("test no restart and clear done");
    pg <= 1'b0;
    wait_st(32'h0001, 50);
    pg <= 1'b1;
    wait_st(32'h0010, 100);
    remote();
    wait_lo(0, 1'b1, 200);
    axr(`TPRS_ADDR_STATUS, rd, rs);
    chk("state f", 32'h8000, rd & 32'h0000ffff);
    bs <= 1'b1;
    wait_st(32'h0001, 50);
    $display("test remote load done");
    wrap_up();
  end

  initial
  begin
    #1000000;
    hang("run");
  end
endmodule : tb_tprs_top
